// file: pkg/ohcid_consts.svh
// Offsets, field positions, reset values and timing counts for caller ID
`ifndef OHCID_CONSTS_SVH
`define OHCID_CONSTS_SVH
// ---------------------------------------------------------------------
// Register offsets of the host controller
// ---------------------------------------------------------------------
`define OHCID_OFS_CTRL     8'h00
`define OHCID_OFS_STATUS   8'h04
`define OHCID_OFS_MASK     8'h08
`define OHCID_OFS_SAMPLE   8'h0C
`define OHCID_OFS_STATE    8'h10
// ---------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------
`define OHCID_CTRL_GO_RING 0
`define OHCID_CTRL_GO_REV  1
`define OHCID_CTRL_DONE    2
`define OHCID_CTRL_OFFHOOK 3
`define OHCID_CTRL_GAIN_LO 4
`define OHCID_CTRL_GAIN_HI 6
// ---------------------------------------------------------------------
// Status and mask fields
// ---------------------------------------------------------------------
`define OHCID_ST_RING      0
`define OHCID_ST_REVERSAL  1
`define OHCID_ST_CAPTURE   2
`define OHCID_ST_SAMPLE    3
`define OHCID_ST_W         4
// ---------------------------------------------------------------------
// Serial sample words of the ring detector
// ---------------------------------------------------------------------
`define OHCID_WORD_POS     16'h7FFF
`define OHCID_WORD_NEG     16'h8000
`define OHCID_WORD_IDLE_FW 16'h04CC
// ---------------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------------
`define OHCID_RST_WORD     32'h0000_0000
`define OHCID_RST_GAIN     3'h0
`define OHCID_ATTEN_MAX    3'h4
`define OHCID_QUAL_MS      40
`define OHCID_CLK_KHZ      10000
`define OHCID_QUAL_CYC     (`OHCID_QUAL_MS * `OHCID_CLK_KHZ)
`endif

// file: pkg/ohcid_pkg.sv
// Types shared by both ends of the caller ID capture link
package ohcid_pkg;
   // Host sequencer states
   typedef enum logic [3:0] {
      OHCID_IDLE      = 4'h0,
      OHCID_OFFHK     = 4'h1,
      OHCID_RING_WAIT = 4'h2,
      OHCID_RING_END  = 4'h3,
      OHCID_REV_WAIT  = 4'h4,
      OHCID_REV_QUAL  = 4'h5,
      OHCID_SET_ACR   = 4'h6,
      OHCID_SET_MODE  = 4'h7,
      OHCID_SET_MON   = 4'h8,
      OHCID_CAPTURE   = 4'h9,
      OHCID_TEARDOWN  = 4'hA
   } ohcid_state_t;
   typedef logic [15:0] ohcid_word_t;
   typedef logic [2:0]  ohcid_gain_t;
endpackage

// file: pkg/ohcid_if.sv
// Control bits, detect flags and sample stream between host and device
`timescale 1ns/10ps
interface ohcid_if;
   import ohcid_pkg::*;
   logic        onhook_monitor_enable;        // Host: line monitor on
   logic        lowpower_select;              // Host: reduced-current ADC
   logic        offhook_request;              // Host: go off-hook
   logic        ac_coupling_reset;            // Host: reset ring coupling
   logic        full_wave_ring_detect_enable; // Host: full-wave detect
   ohcid_gain_t receive_gain_select;          // Host: gain/attenuation
   logic        flag_clear;                   // Host: clear both flags
   logic        ring_detect_positive_flag;    // Device: sticky flag
   logic        ring_detect_negative_flag;    // Device: sticky flag
   ohcid_word_t serial_sample_output;         // Device: sample word
   logic        sample_valid;                 // Device: word strobe
   modport dev (
      input  onhook_monitor_enable,
      input  lowpower_select,
      input  offhook_request,
      input  ac_coupling_reset,
      input  full_wave_ring_detect_enable,
      input  receive_gain_select,
      input  flag_clear,
      output ring_detect_positive_flag,
      output ring_detect_negative_flag,
      output serial_sample_output,
      output sample_valid
   );
   modport hst (
      output onhook_monitor_enable,
      output lowpower_select,
      output offhook_request,
      output ac_coupling_reset,
      output full_wave_ring_detect_enable,
      output receive_gain_select,
      output flag_clear,
      input  ring_detect_positive_flag,
      input  ring_detect_negative_flag,
      input  serial_sample_output,
      input  sample_valid
   );
endinterface

// file: verilog/ohcid_device.sv
// Line-side end: converter select, ring flags and sample stream
`timescale 1ns/10ps
`include "ohcid_consts.svh"
module ohcid_device (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   ohcid_if.dev             link,
   input  wire logic        ring_pos_pin,
   input  wire logic        ring_neg_pin,
   input  wire ohcid_pkg::ohcid_word_t adc_sample,
   input  wire logic        adc_valid,
   output logic             std_adc_en,
   output logic             lowpwr_adc_en,
   output ohcid_pkg::ohcid_gain_t lp_atten_sel,
   output logic             ac_reset_drive,
   output logic             offhook_drive
);
   import ohcid_pkg::*;

   // -----------------------------------------------------------------
   // Pin synchronisers and edge detect
   // -----------------------------------------------------------------
   logic [1:0] pos_sync_q;  // Positive comparator stages
   logic [1:0] neg_sync_q;  // Negative comparator stages
   logic       pos_old_q;   // Last synced positive level
   logic       neg_old_q;   // Last synced negative level
   logic       pos_rise;    // New positive excursion
   logic       neg_rise;    // New negative excursion
   logic       mon_lp;      // Reduced-current monitor active

   // Clamp gain codes above the top step to the 5 dB setting
   function automatic ohcid_gain_t atten_code(input ohcid_gain_t g);
      atten_code = (g > `OHCID_ATTEN_MAX) ? `OHCID_ATTEN_MAX : g;
   endfunction

   // Two stages before any logic looks at the pins
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pos_sync_q <= 2'h0;
         neg_sync_q <= 2'h0;
         pos_old_q  <= 1'b0;
         neg_old_q  <= 1'b0;
      end
      else
      begin
         pos_sync_q <= {pos_sync_q[0], ring_pos_pin};
         neg_sync_q <= {neg_sync_q[0], ring_neg_pin};
         pos_old_q  <= pos_sync_q[1];
         neg_old_q  <= neg_sync_q[1];
      end
   end

   // A reversal crosses a threshold just as a ring half-cycle does
   assign pos_rise = pos_sync_q[1] & ~pos_old_q;
   assign neg_rise = neg_sync_q[1] & ~neg_old_q;
   assign mon_lp   = link.onhook_monitor_enable & link.lowpower_select;

   // -----------------------------------------------------------------
   // Sticky detect flags
   // -----------------------------------------------------------------
   // Set wins over clear, so an edge in the clear cycle survives
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         link.ring_detect_positive_flag <= 1'b0;
         link.ring_detect_negative_flag <= 1'b0;
      end
      else
      begin
         if (pos_rise)
            link.ring_detect_positive_flag <= 1'b1;
         else if (link.flag_clear)
            link.ring_detect_positive_flag <= 1'b0;
         if (neg_rise)
            link.ring_detect_negative_flag <= 1'b1;
         else if (link.flag_clear)
            link.ring_detect_negative_flag <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Converter select and line controls
   // -----------------------------------------------------------------
   // Mode bit swaps the 450 mA converter for the 7 mA one
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         std_adc_en     <= 1'b0;
         lowpwr_adc_en  <= 1'b0;
         lp_atten_sel   <= `OHCID_RST_GAIN;
         ac_reset_drive <= 1'b0;
         offhook_drive  <= 1'b0;
      end
      else
      begin
         std_adc_en    <= link.onhook_monitor_enable
                          & ~link.lowpower_select;
         lowpwr_adc_en <= mon_lp;
         // Gain field doubles as input attenuator in this mode
         lp_atten_sel  <= mon_lp ? atten_code(link.receive_gain_select)
                                 : `OHCID_RST_GAIN;
         ac_reset_drive <= link.ac_coupling_reset;
         offhook_drive  <= link.offhook_request;
      end
   end

   // -----------------------------------------------------------------
   // Serial sample output
   // -----------------------------------------------------------------
   // Monitor forwards converter words; otherwise ring detector words
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         link.serial_sample_output <= `OHCID_WORD_NEG;
         link.sample_valid         <= 1'b0;
      end
      else
      begin
         link.sample_valid <= adc_valid;
         if (adc_valid)
         begin
            if (link.onhook_monitor_enable)
               link.serial_sample_output <= adc_sample;
            else if (pos_sync_q[1])
               link.serial_sample_output <= `OHCID_WORD_POS;
            else if (neg_sync_q[1] & link.full_wave_ring_detect_enable)
               link.serial_sample_output <= `OHCID_WORD_NEG;
            else if (link.full_wave_ring_detect_enable)
               link.serial_sample_output <= `OHCID_WORD_IDLE_FW;
            else
               // Half-wave idles low so the sign bit follows the ring
               link.serial_sample_output <= `OHCID_WORD_NEG;
         end
      end
   end
endmodule

// file: verilog/ohcid_host.sv
// Host end: AHB-Lite registers and caller ID capture sequencer
`timescale 1ns/10ps
`include "ohcid_consts.svh"
// How it works
// - Monitor enable turns on standard converter
// - Mode plus enable picks reduced-current converter
// - Clear monitor enable before requesting off-hook
// - Gain field attenuates reduced-current converter input
// - Prefer reduced-current converter for monitoring
// - After first ring, hold coupling reset
// - Set mode first, then monitor enable
// - Converter streams ring-pin samples to DSP
// - Clear enable, mode, reset before next ring
// - Enable full-wave detect for reversal capture
// - Reversal trips a ring detect flag
// - Edge within 40 ms means ring
// - Confirmed reversal: reset, then mode, enable
// - Full-wave words: 1228 idle, full scale
// - Sample sign bit follows ring frequency
module ohcid_host #(
   parameter int QUAL_CYCLES = `OHCID_QUAL_CYC,
   parameter int CNT_W       = 20
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq,
   ohcid_if.hst             link
);
   import ohcid_pkg::*;

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   localparam logic [CNT_W-1:0] QUAL_LAST = CNT_W'(QUAL_CYCLES - 1);
   ohcid_state_t            st_q;        // Sequencer state
   ohcid_state_t            st_d;        // Next state
   logic [CNT_W-1:0]        cnt_q;       // Quiet-time counter
   logic                    wr_q;        // Write data phase pending
   logic [7:0]              wadr_q;      // Latched write offset
   logic                    offhk_q;     // Software off-hook level
   ohcid_gain_t             gain_q;      // Software gain field
   logic                    go_ring_q;   // Between-ring start pulse
   logic                    go_rev_q;    // Reversal start pulse
   logic                    done_q;      // Data received pulse
   logic [`OHCID_ST_W-1:0]  stat_q;      // Sticky events
   logic [`OHCID_ST_W-1:0]  mask_q;      // Interrupt mask
   logic [`OHCID_ST_W-1:0]  ev;          // Events this cycle
   ohcid_word_t             smp_q;       // Last captured sample
   logic                    rd_acc;      // Read taken this edge
   logic                    wr_acc;      // Write taken this edge
   logic                    edge_seen;   // Fresh detect flag
   logic                    quiet_done;  // 40 ms without an edge

   // Accepted transfer in the address phase
   function automatic logic take(input logic wr);
      take = hsel & htrans[1] & hready & (hwrite == wr);
   endfunction

   assign rd_acc = take(1'b0);
   assign wr_acc = take(1'b1);
   // Flags still high during our own clear are not new edges
   assign edge_seen  = (link.ring_detect_positive_flag
                       | link.ring_detect_negative_flag)
                       & ~link.flag_clear;
   assign quiet_done = (cnt_q == QUAL_LAST);

   // -----------------------------------------------------------------
   // Bus slave
   // -----------------------------------------------------------------
   // Zero wait states; write data lands one edge after its address
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_q      <= 1'b0;
         wadr_q    <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         wr_q      <= wr_acc;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (wr_acc)
            wadr_q <= haddr[7:0];
      end
   end

   // Read data registered at the address edge, valid in data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= `OHCID_RST_WORD;
      else if (rd_acc)
      begin
         unique case (haddr[7:0])
            `OHCID_OFS_CTRL:
               hrdata <= {25'h0, gain_q, offhk_q, 3'h0};
            `OHCID_OFS_STATUS: hrdata <= {28'h0, stat_q};
            `OHCID_OFS_MASK:   hrdata <= {28'h0, mask_q};
            `OHCID_OFS_SAMPLE: hrdata <= {16'h0, smp_q};
            `OHCID_OFS_STATE:  hrdata <= {28'h0, st_q};
            // Unmapped offsets read as zero
            default:           hrdata <= `OHCID_RST_WORD;
         endcase
      end
   end

   // Control register and command pulses
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         offhk_q   <= 1'b0;
         gain_q    <= `OHCID_RST_GAIN;
         go_ring_q <= 1'b0;
         go_rev_q  <= 1'b0;
         done_q    <= 1'b0;
         mask_q    <= '0;
      end
      else
      begin
         go_ring_q <= 1'b0;
         go_rev_q  <= 1'b0;
         done_q    <= 1'b0;
         if (wr_q && wadr_q == `OHCID_OFS_CTRL)
         begin
            go_ring_q <= hwdata[`OHCID_CTRL_GO_RING];
            go_rev_q  <= hwdata[`OHCID_CTRL_GO_REV];
            done_q    <= hwdata[`OHCID_CTRL_DONE];
            offhk_q   <= hwdata[`OHCID_CTRL_OFFHOOK];
            gain_q    <= hwdata[`OHCID_CTRL_GAIN_HI:`OHCID_CTRL_GAIN_LO];
         end
         if (wr_q && wadr_q == `OHCID_OFS_MASK)
            mask_q <= hwdata[`OHCID_ST_W-1:0];
      end
   end

   // -----------------------------------------------------------------
   // Interrupt status
   // -----------------------------------------------------------------
   always_comb
   begin
      ev = '0;
      ev[`OHCID_ST_RING]     = (st_q == OHCID_REV_QUAL) & edge_seen;
      ev[`OHCID_ST_REVERSAL] = (st_q == OHCID_REV_QUAL) & quiet_done
                               & ~edge_seen;
      ev[`OHCID_ST_CAPTURE]  = (st_q == OHCID_SET_MON);
      ev[`OHCID_ST_SAMPLE]   = (st_q == OHCID_CAPTURE) & link.sample_valid;
   end

   // Read clears, but an event in the same cycle stays set
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         stat_q <= '0;
         irq    <= 1'b0;
         smp_q  <= 16'h0000;
      end
      else
      begin
         if (rd_acc && haddr[7:0] == `OHCID_OFS_STATUS)
            stat_q <= ev;
         else
            stat_q <= stat_q | ev;
         irq <= |((stat_q | ev) & mask_q);
         if (ev[`OHCID_ST_SAMPLE])
            smp_q <= link.serial_sample_output;
      end
   end

   // -----------------------------------------------------------------
   // Capture sequencer
   // -----------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      unique case (st_q)
         OHCID_IDLE:
            // Monitor is already off here before going off-hook
            if (offhk_q)
               st_d = OHCID_OFFHK;
            else if (go_rev_q)
               st_d = OHCID_REV_WAIT;
            else if (go_ring_q)
               st_d = OHCID_RING_WAIT;
         OHCID_OFFHK:
            if (!offhk_q)
               st_d = OHCID_IDLE;
         OHCID_RING_WAIT:
            if (edge_seen)
               st_d = OHCID_RING_END;
         OHCID_RING_END:
            // First ring over once its edges stop for the interval
            if (quiet_done && !edge_seen)
               st_d = OHCID_SET_ACR;
         OHCID_REV_WAIT:
            if (edge_seen)
               st_d = OHCID_REV_QUAL;
         OHCID_REV_QUAL:
            if (edge_seen)
               st_d = OHCID_REV_WAIT;
            else if (quiet_done)
               st_d = OHCID_SET_ACR;
         OHCID_SET_ACR:  st_d = OHCID_SET_MODE;
         OHCID_SET_MODE: st_d = OHCID_SET_MON;
         OHCID_SET_MON:  st_d = OHCID_CAPTURE;
         OHCID_CAPTURE:
            if (done_q || offhk_q)
               st_d = OHCID_TEARDOWN;
         OHCID_TEARDOWN: st_d = OHCID_IDLE;
         default:        st_d = OHCID_IDLE;
      endcase
      // Off-hook abandons any wait; a live monitor ends via OHCID_TEARDOWN
      if (offhk_q && st_q inside {OHCID_RING_WAIT, OHCID_RING_END,
                                  OHCID_REV_WAIT, OHCID_REV_QUAL})
         st_d = OHCID_IDLE;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st_q <= OHCID_IDLE;
      else
         st_q <= st_d;
   end

   // Quiet counter restarts on every edge and on entering a wait
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cnt_q <= '0;
      else if (edge_seen || st_q != st_d)
         cnt_q <= '0;
      else if (!quiet_done)
         cnt_q <= cnt_q + 1'b1;
   end

   // -----------------------------------------------------------------
   // Line control bits
   // -----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         link.onhook_monitor_enable        <= 1'b0;
         link.lowpower_select              <= 1'b0;
         link.offhook_request              <= 1'b0;
         link.ac_coupling_reset            <= 1'b0;
         link.full_wave_ring_detect_enable <= 1'b0;
         link.receive_gain_select          <= `OHCID_RST_GAIN;
         link.flag_clear                   <= 1'b0;
      end
      else
      begin
         link.receive_gain_select <= gain_q;
         link.flag_clear          <= edge_seen;
         link.offhook_request     <= (st_q == OHCID_OFFHK)
                                     & offhk_q;
         if (st_d == OHCID_REV_WAIT)
            link.full_wave_ring_detect_enable <= 1'b1;
         if (st_q == OHCID_SET_ACR)
            link.ac_coupling_reset <= 1'b1;
         // Always the 7 mA converter, ahead of the enable
         if (st_q == OHCID_SET_MODE)
            link.lowpower_select <= 1'b1;
         if (st_q == OHCID_SET_MON)
            link.onhook_monitor_enable <= 1'b1;
         if (st_q == OHCID_TEARDOWN)
         begin
            link.onhook_monitor_enable        <= 1'b0;
            link.lowpower_select              <= 1'b0;
            link.ac_coupling_reset            <= 1'b0;
            link.full_wave_ring_detect_enable <= 1'b0;
         end
         if (st_q == OHCID_IDLE && st_d != OHCID_REV_WAIT)
            link.full_wave_ring_detect_enable <= 1'b0;
      end
   end
endmodule

// file: verification/ohcid_link_sva.sv
// Assertions on the caller ID link
`timescale 1ns/10ps
module ohcid_link_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic onhook_monitor_enable,
   input wire logic lowpower_select,
   input wire logic offhook_request,
   input wire logic ac_coupling_reset,
   input wire logic full_wave_ring_detect_enable,
   input wire logic flag_clear,
   input wire logic ring_detect_positive_flag,
   input wire logic ring_detect_negative_flag,
   input wire ohcid_pkg::ohcid_word_t serial_sample_output,
   input wire logic sample_valid
);
   import ohcid_pkg::*;
   // ------------
   // Control bit order
   // ------------
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_mode_first: assert property (
      $rose(onhook_monitor_enable) |-> $past(lowpower_select))
      else $error("enable before mode");
   chk_acr_first: assert property (
      $rose(lowpower_select) |-> $past(ac_coupling_reset))
      else $error("mode before reset");
   chk_mon_mode: assert property (
      onhook_monitor_enable |-> lowpower_select)
      else $error("enable without mode");
   chk_offhook_quiet: assert property (
      $rose(offhook_request) |-> !onhook_monitor_enable
         && !$past(onhook_monitor_enable))
      else $error("off-hook with monitor on");
   chk_teardown_all: assert property (
      $fell(onhook_monitor_enable) |-> !lowpower_select && !ac_coupling_reset)
      else $error("teardown incomplete");
   chk_clear_cause: assert property (
      flag_clear |-> ring_detect_positive_flag || ring_detect_negative_flag)
      else $error("clear without flag");
   // Words hold once the path is settled
   chk_fw_words: assert property (
      sample_valid && full_wave_ring_detect_enable && !onhook_monitor_enable
         && !$past(onhook_monitor_enable) |-> serial_sample_output inside
         {16'h7FFF, 16'h8000, 16'h04CC})
      else $error("bad full-wave word");
   chk_hw_words: assert property (
      sample_valid && !full_wave_ring_detect_enable
         && !$past(full_wave_ring_detect_enable) && !onhook_monitor_enable
         && !$past(onhook_monitor_enable) |-> serial_sample_output inside
         {16'h7FFF, 16'h8000})
      else $error("bad half-wave word");
   cover property ($rose(onhook_monitor_enable));
   cover property ($rose(offhook_request));
   cover property (flag_clear && full_wave_ring_detect_enable);
endmodule

// file: verification/onhook_caller_id_capture_test.sv
// Self-checking bench for the caller ID link
`timescale 1ns/10ps
`include "ohcid_consts.svh"
module onhook_caller_id_capture_test;
   import ohcid_pkg::*;
   // ------------
   // Bench signals
   // ------------
   logic        hclk = 1'b0;         // 10 MHz bus clock
   logic        hresetn = 1'b0;      // Async reset, low
   logic        hsel = 1'b0;         // Bus select
   logic [31:0] haddr = 32'h0;       // Bus address
   logic [1:0]  htrans = 2'h0;       // Transfer kind
   logic        hwrite = 1'b0;       // Write strobe
   logic [31:0] hwdata = 32'h0;      // Write data
   logic [31:0] hrdata, rd;          // Read data, last read
   logic        hreadyout, hresp;    // Slave answer
   logic        irq;                 // Level interrupt
   logic        pos_pin = 1'b0;      // Comparator above threshold
   logic        neg_pin = 1'b0;      // Comparator below threshold
   logic        adc_valid = 1'b0;    // Converter strobe
   ohcid_word_t adc_sample = 16'h0;  // Converter word
   logic        std_en, lp_en, oh, acr; // Line-side drives
   ohcid_gain_t atten;               // Attenuator code
   int          fails = 0;
   int          tests_run = 0;
   ohcid_if link ();
   always #50 hclk = ~hclk;
   // Short qualification
   ohcid_host #(.QUAL_CYCLES(50)) ohcid_host_i (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
      .link(link));
   ohcid_device ohcid_device_i (.hclk(hclk), .hresetn(hresetn), .link(link),
      .ring_pos_pin(pos_pin), .ring_neg_pin(neg_pin), .adc_sample(adc_sample),
      .adc_valid(adc_valid), .std_adc_en(std_en), .lowpwr_adc_en(lp_en),
      .lp_atten_sel(atten), .ac_reset_drive(acr), .offhook_drive(oh));
   ohcid_link_sva ohcid_link_sva_i (.hclk(hclk), .hresetn(hresetn),
      .onhook_monitor_enable(link.onhook_monitor_enable),
      .lowpower_select(link.lowpower_select),
      .offhook_request(link.offhook_request),
      .ac_coupling_reset(link.ac_coupling_reset),
      .full_wave_ring_detect_enable(link.full_wave_ring_detect_enable),
      .flag_clear(link.flag_clear),
      .ring_detect_positive_flag(link.ring_detect_positive_flag),
      .ring_detect_negative_flag(link.ring_detect_negative_flag),
      .serial_sample_output(link.serial_sample_output),
      .sample_valid(link.sample_valid));
   // ------------
   // Shared tasks
   // ------------
   task automatic chk(input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // One word transfer; read data taken at data edge
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // Pulse long enough to pass the synchroniser
   task automatic ring(input logic p);
      @(posedge hclk);
      pos_pin <= p;
      neg_pin <= !p;
      cyc(4);
      pos_pin <= 1'b0;
      neg_pin <= 1'b0;
   endtask
   task automatic samp(input ohcid_word_t d, exp);
      @(posedge hclk);
      adc_sample <= d;
      adc_valid <= 1'b1;
      @(posedge hclk);
      adc_valid <= 1'b0;
      cyc(2);
      chk(link.serial_sample_output, exp);
   endtask
   task automatic wait_mon;
      for (int i = 0; i < 300 && lp_en !== 1'b1; i++)
         @(negedge hclk);
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ------------
   // Scenarios
   // ------------
   task automatic t_between;
      rdchk(8'h20, 32'h0);
      ahb(1'b1, `OHCID_OFS_MASK, 32'hF);
      ahb(1'b1, `OHCID_OFS_CTRL, 32'h71);
      cyc(4);
      ring(1'b1);
      wait_mon();
      chk(link.lowpower_select, 1'b1);
      chk(link.ac_coupling_reset, 1'b1);
      chk({std_en, lp_en}, 2'b01);
      chk(atten, `OHCID_ATTEN_MAX);
      samp(16'h1234, 16'h1234);
      chk(irq, 1'b1);
      rdchk(`OHCID_OFS_STATUS, 32'hC);
      cyc(2);
      chk(irq, 1'b0);
      ahb(1'b1, `OHCID_OFS_CTRL, 32'h74);
      cyc(4);
      chk({link.onhook_monitor_enable, link.lowpower_select,
           link.ac_coupling_reset}, 3'h0);
      rdchk(`OHCID_OFS_STATE, 32'h0);
      $display("between-ring test done");
   endtask
   task automatic t_reversal;
      ahb(1'b1, `OHCID_OFS_MASK, 32'h0);
      ahb(1'b1, `OHCID_OFS_CTRL, 32'h2);
      cyc(4);
      chk(link.full_wave_ring_detect_enable, 1'b1);
      samp(16'h1111, `OHCID_WORD_IDLE_FW);
      chk(irq, 1'b0);
      rdchk(`OHCID_OFS_STATUS, 32'h0);
      ahb(1'b1, `OHCID_OFS_MASK, 32'hF);
      ring(1'b1);
      cyc(10);
      ring(1'b0);
      cyc(80);
      rdchk(`OHCID_OFS_STATUS, 32'h1);
      chk(link.onhook_monitor_enable, 1'b0);
      ring(1'b1);
      wait_mon();
      cyc(2);
      rdchk(`OHCID_OFS_STATUS, 32'h6);
      chk({link.ac_coupling_reset, acr}, 2'b11);
      $display("reversal test done");
   endtask
   task automatic t_offhook;
      ahb(1'b1, `OHCID_OFS_CTRL, 32'h8);
      cyc(8);
      chk(link.onhook_monitor_enable, 1'b0);
      chk({link.offhook_request, oh}, 2'b11);
      rdchk(`OHCID_OFS_CTRL, 32'h8);
      samp(16'h2222, `OHCID_WORD_NEG);
      $display("off-hook test done");
   endtask
   initial
   begin
      cyc(16);
      hresetn <= 1'b1;
      t_between();
      t_reversal();
      t_offhook();
      results();
   end
   // Watchdog far past the test length
   initial
   begin
      cyc(20000);
      fails++;
      results();
   end
endmodule
